/* File: dv/bsc_jtag_master.sv */
// test-port master model: paces tck from the system clock, drives tms/tdi, samples tdo
`timescale 1ns/100ps

module bsc_jtag_master (
    // pacing clock
    input wire logic clk_in,
    // test access port
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_n_in
);
    // 80 ns phases, 160 ns period at a 4 ns system clock
    localparam int HALF = 20;

    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // tck rests low between frames; tms/tdi only move while tck is low
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        repeat (HALF) @(posedge clk_in);
        #1;
        // released tdo reads as the board pull-up
        tdo = tdo_oe_n_in ? 1'b1 : tdo_in;
        tck_out = 1'b1;
        repeat (HALF) @(posedge clk_in);
        #1;
        tck_out = 1'b0;
    endtask : step

    // from idle: scan n bits lsb first through the instruction or data path, back to idle
    task automatic scan(input logic ir, input logic [15:0] din, input int n, output logic [15:0] dout);
        logic t;
        dout = '0;
        step(1'b1, 1'b0, t);
        if (ir) step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask : scan

    // five rises with tms high, then park in idle
    task automatic go_reset();
        logic t;
        repeat (5) step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask : go_reset
endmodule : bsc_jtag_master

/* File: dv/bsc_tap_top_tb_top.sv */
// self-checking bench of the boundary-scan test port
`timescale 1ns/100ps
`include "bsc_map.svh"

module bsc_tap_top_tb_top;
    localparam int NCFG = 2;
    localparam int NBD = 2;
    localparam int BB = 2 + NCFG;
    localparam int LEN = BB + 2 * NBD;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe_n;
    logic trst_n = 1'b1;
    logic enum_core = 1'b1;
    logic enum_oe_core = 1'b0;
    logic enum_n, enum_oe_n;
    logic [NCFG-1:0] cfg_pin = '0;
    logic [NCFG-1:0] cfg_core;
    logic [NBD-1:0] io_pin_in, io_pin_out, io_oe_n, io_core_out;
    logic [NBD-1:0] io_core_data = '0;
    logic [NBD-1:0] io_core_oe = '0;
    logic [NBD-1:0] io_ext = '0;
    logic [`BSC_IR_W-1:0] instr, evt_data;
    logic evt_valid, evt_space;
    logic evt_ready = 1'b1;
    logic [`BSC_IR_W-1:0] exp_q[$];
    logic [LEN-1:0] p, q;
    logic [15:0] b, dout;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 88120;

    // pin level: our drive when enabled, else the board's value
    for (genvar k = 0; k < NBD; k++) begin : g_pin
        assign io_pin_in[k] = io_oe_n[k] ? io_ext[k] : io_pin_out[k];
    end

    initial forever #2 clk = ~clk;

    bsc_tap_top #(.NUM_CFG(NCFG), .NUM_BIDIR(NBD), .EVT_DEPTH(2)) i_dut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
        .TRST_N_IN(trst_n), .TDO_OUT(tdo), .TDO_OE_N_OUT(tdo_oe_n),
        .ENUM_N_CORE_IN(enum_core), .ENUM_OE_CORE_IN(enum_oe_core), .ENUM_N_OUT(enum_n),
        .ENUM_OE_N_OUT(enum_oe_n), .CFG_PIN_IN(cfg_pin), .CFG_CORE_OUT(cfg_core),
        .IO_PIN_IN(io_pin_in), .IO_PIN_OUT(io_pin_out), .IO_OE_N_OUT(io_oe_n),
        .IO_CORE_DATA_IN(io_core_data), .IO_CORE_OE_IN(io_core_oe), .IO_CORE_DATA_OUT(io_core_out),
        .INSTR_OUT(instr), .INSTR_EVT_VALID_OUT(evt_valid), .INSTR_EVT_DATA_OUT(evt_data),
        .INSTR_EVT_READY_IN(evt_ready), .INSTR_EVT_SPACE_OUT(evt_space)
    );

    bsc_jtag_master i_master (
        .clk_in(clk), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    function automatic logic lvl(input int k, input logic ext, input logic [LEN-1:0] u);
        return (ext ? u[BB+2*k+1] : io_core_oe[k]) ? (ext ? u[BB+2*k] : io_core_data[k]) : io_ext[k];
    endfunction : lvl

    // what capture-dr should load, given the update cells now in force
    function automatic logic [LEN-1:0] exp_cap(input logic ext, input logic [LEN-1:0] u);
        logic [LEN-1:0] e;
        e[0] = ext ? u[0] : enum_core;
        e[1] = ext ? u[1] : enum_oe_core;
        e[2 +: NCFG] = cfg_pin;
        for (int k = 0; k < NBD; k++) begin
            e[BB+2*k] = lvl(k, ext, u);
            e[BB+2*k+1] = ext ? u[BB+2*k+1] : io_core_oe[k];
        end
        return e;
    endfunction : exp_cap

    task automatic chk_pins(input logic ext, input logic [LEN-1:0] u);
        check("enum_n", enum_n, ext ? u[0] : enum_core);
        check("enum_oe_n", enum_oe_n, ext ? !u[1] : !enum_oe_core);
        check("cfg_core", cfg_core, ext ? u[2 +: NCFG] : cfg_pin);
        for (int k = 0; k < NBD; k++) begin
            check("io_pin_out", io_pin_out[k], ext ? u[BB+2*k] : io_core_data[k]);
            check("io_oe_n", io_oe_n[k], ext ? !u[BB+2*k+1] : !io_core_oe[k]);
            check("io_core_out", io_core_out[k], ext ? u[BB+2*k] : lvl(k, 1'b0, u));
        end
    endtask : chk_pins

    // the note goes in before the scan: the event can pop before the scan returns
    task automatic ir_load(input logic [`BSC_IR_W-1:0] code, input logic push);
        logic [15:0] d;
        if (push) exp_q.push_back(code);
        i_master.scan(1'b1, 16'(code), `BSC_IR_W, d);
        check("ir_capture", d[`BSC_IR_W-1:0], `BSC_IR_CAPTURE);
        wait_clk(6);
        check("instr", instr, code);
        check("tdo_oe_n", tdo_oe_n, 1'b1);
    endtask : ir_load

    task automatic dr_scan(input logic ext, input logic [LEN-1:0] u_old, input logic [LEN-1:0] din);
        logic [15:0] d;
        i_master.scan(1'b0, 16'(din), LEN, d);
        check("dr_capture", d[LEN-1:0], exp_cap(ext, u_old));
        wait_clk(6);
        chk_pins(ext, din);
    endtask : dr_scan

    always @(posedge clk) begin
        if (evt_valid === 1'b1 && evt_ready === 1'b1) begin
            if (exp_q.size() == 0) check("evt_extra", 16'h1, 16'h0);
            else check("evt_data", evt_data, exp_q.pop_front());
        end
    end

    initial begin
        #100000;
        check("timeout", 16'h1, 16'h0);
        print_verdict();
    end

    initial begin
        enum_core = 1'($random(seed));
        enum_oe_core = 1'($random(seed));
        cfg_pin = NCFG'($random(seed));
        io_core_data = NBD'($random(seed));
        io_core_oe = NBD'($random(seed));
        io_ext = NBD'($random(seed));
        p = LEN'($random(seed));
        q = LEN'($random(seed));
        q[BB+1] = 1'b0;
        q[BB+3] = 1'b1;
        // enumeration control cell seen both ways under extest
        p[1] = 1'b1;
        q[1] = 1'b0;
        wait_clk(5);
        rst = 1'b0;
        wait_clk(8);
        check("instr_rst", instr, `BSC_OP_IDCODE);
        check("tdo_oe_rst", tdo_oe_n, 1'b1);
        chk_pins(1'b0, '0);
        i_master.go_reset();
        $display("test reset done");
        ir_load(`BSC_OP_SAMPLE, 1'b1);
        dr_scan(1'b0, '0, p);
        ir_load(`BSC_OP_EXTEST, 1'b1);
        chk_pins(1'b1, p);
        dr_scan(1'b1, p, q);
        $display("test boundary done");
        // an unlisted code must fall back to the one-bit path; the reserved one stays unused
        for (int i = 0; i < 2; i++) begin
            ir_load(i == 0 ? `BSC_OP_BYPASS : 4'h3, 1'b1);
            chk_pins(1'b0, q);
            b = 16'($random(seed));
            i_master.scan(1'b0, b, LEN + 1, dout);
            check("bypass", dout[LEN:0], {b[LEN-1:0], 1'b0});
        end
        $display("test bypass done");
        evt_ready = 1'b0;
        ir_load(`BSC_OP_SAMPLE, 1'b1);
        ir_load(`BSC_OP_BYPASS, 1'b1);
        check("evt_space", evt_space, 1'b0);
        ir_load(`BSC_OP_EXTEST, 1'b0);
        evt_ready = 1'b1;
        wait_clk(6);
        check("evt_drain", 16'(exp_q.size()), 16'h0);
        $display("test buffer done");
        i_master.go_reset();
        check("instr_tms", instr, `BSC_OP_IDCODE);
        wait_clk(6);
        check("evt_tms", 16'(exp_q.size()), 16'h0);
        ir_load(`BSC_OP_EXTEST, 1'b1);
        trst_n = 1'b0;
        wait_clk(6);
        check("instr_trst", instr, `BSC_OP_IDCODE);
        check("tdo_oe_trst", tdo_oe_n, 1'b1);
        trst_n = 1'b1;
        wait_clk(6);
        i_master.go_reset();
        ir_load(`BSC_OP_SAMPLE, 1'b1);
        wait_clk(6);
        check("evt_end", 16'(exp_q.size()), 16'h0);
        $display("test resets done");
        print_verdict();
    end
endmodule : bsc_tap_top_tb_top

/* File: hw/bsc_evt_fifo.sv */
// small first-in first-out buffer for instruction-change events, head always in a flop
`timescale 1ns/100ps
`include "bsc_map.svh"

module bsc_evt_fifo #(
    parameter int WIDTH = `BSC_IR_W,
    parameter int DEPTH = `BSC_EVT_DEPTH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // filling side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // draining side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
            $error("bsc_evt_fifo needs DEPTH >= 2 and WIDTH >= 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [CW-1:0] wr_pos;
    logic push;
    logic pop;

    assign pop = out_valid_out & out_ready_in;
    assign push = in_valid_in & in_ready_out;
    // entries slide toward the head on a pop, so the head never needs a read mux
    assign wr_pos = cnt - {{(CW-1){1'b0}}, pop};

    always_comb begin
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_comb begin
                next_mem[i] = mem[i];
                if (pop) begin
                    next_mem[i] = (i < DEPTH - 1) ? mem[(i < DEPTH - 1) ? i + 1 : i] : '0;
                end
                if (push && wr_pos == CW'(i)) begin
                    next_mem[i] = in_data_in;
                end
            end

            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    mem[i] <= '0;
                end else begin
                    mem[i] <= next_mem[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= '0;
            out_valid_out <= 1'b0;
            in_ready_out <= 1'b1;
        end else begin
            cnt <= next_cnt;
            out_valid_out <= (next_cnt != '0);
            in_ready_out <= (next_cnt < CW'(DEPTH));
        end
    end

    assign out_data_out = mem[0];

endmodule : bsc_evt_fifo

/* File: hw/bsc_map.svh */
// constants of the boundary-scan test port: opcodes, chain layout, timing counts
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

`define BSC_IR_W 4
`define BSC_OP_EXTEST 4'h0
`define BSC_OP_SAMPLE 4'h1
`define BSC_OP_IDCODE 4'h5
`define BSC_OP_BYPASS 4'hf
`define BSC_IR_CAPTURE 4'hd

`define BSC_POS_ENUM_DATA 0
`define BSC_POS_ENUM_CTRL 1
`define BSC_POS_CFG_BASE 2
`define BSC_CFG_CELLS 11
`define BSC_BIDIR_PINS 4

`define BSC_TLR_TMS_RISES 5
`define BSC_EVT_DEPTH 2

`endif

/* File: hw/bsc_pkg.sv */
// types of the boundary-scan test port
package bsc_pkg;

    typedef enum logic [3:0] {
        ST_EXIT2_DR   = 4'b0000,
        ST_EXIT1_DR   = 4'b0001,
        ST_SHIFT_DR   = 4'b0010,
        ST_PAUSE_DR   = 4'b0011,
        ST_SELECT_IR  = 4'b0100,
        ST_UPDATE_DR  = 4'b0101,
        ST_CAPTURE_DR = 4'b0110,
        ST_SELECT_DR  = 4'b0111,
        ST_EXIT2_IR   = 4'b1000,
        ST_EXIT1_IR   = 4'b1001,
        ST_SHIFT_IR   = 4'b1010,
        ST_PAUSE_IR   = 4'b1011,
        ST_IDLE       = 4'b1100,
        ST_UPDATE_IR  = 4'b1101,
        ST_CAPTURE_IR = 4'b1110,
        ST_RESET      = 4'b1111
    } bsc_tap_state_t;

endpackage : bsc_pkg

/* File: hw/bsc_tap_top.sv */
// boundary-scan test port: tap controller, instruction and data registers, boundary cells
`timescale 1ns/100ps
`include "bsc_map.svh"

// Notes on behaviour
// - four-bit master/slave instruction register, rising-edge shift
// - latched instruction replaces and stops previous one
// - instruction capture loads 1101
// - instruction shifts in at msb, out lsb
// - test reset forces identification instruction without clock
// - new instruction takes effect on falling edge
// - decode 0000 extest, 0001 sample, 1111 bypass
// - extest drives outputs from cells, falling edge
// - extest captures input pins on rising edge
// - sample captures pins without disturbing operation
// - sample copies master cells to slave cells
// - bypass: one-bit register, system keeps working
// - data enters msb, leaves lsb, no inversion
// - zero in control cell releases the pin
// - one cell per pin plus control cells
// - cell data and tdo change on falling edge
// - controller moves only on rising test clock or a reset
// - test reset low returns controller to reset
// - five rises with mode high reach reset
// - chain starts with enumeration output and control
// - controller is the standard sixteen-state machine
// - power-on reset puts controller in reset

module bsc_tap_top import bsc_pkg::*; #(
    parameter int NUM_CFG = `BSC_CFG_CELLS,
    parameter int NUM_BIDIR = `BSC_BIDIR_PINS,
    parameter int EVT_DEPTH = `BSC_EVT_DEPTH
) (
    // clock and power-on reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // test access port
    input wire logic TCK_IN,
    input wire logic TMS_IN,
    input wire logic TDI_IN,
    input wire logic TRST_N_IN,
    output logic TDO_OUT,
    output logic TDO_OE_N_OUT,
    // enumeration output pin
    input wire logic ENUM_N_CORE_IN,
    input wire logic ENUM_OE_CORE_IN,
    output logic ENUM_N_OUT,
    output logic ENUM_OE_N_OUT,
    // configuration input pins
    input wire logic [NUM_CFG-1:0] CFG_PIN_IN,
    output logic [NUM_CFG-1:0] CFG_CORE_OUT,
    // bidirectional pins
    input wire logic [NUM_BIDIR-1:0] IO_PIN_IN,
    output logic [NUM_BIDIR-1:0] IO_PIN_OUT,
    output logic [NUM_BIDIR-1:0] IO_OE_N_OUT,
    input wire logic [NUM_BIDIR-1:0] IO_CORE_DATA_IN,
    input wire logic [NUM_BIDIR-1:0] IO_CORE_OE_IN,
    output logic [NUM_BIDIR-1:0] IO_CORE_DATA_OUT,
    // active instruction and its change events
    output logic [`BSC_IR_W-1:0] INSTR_OUT,
    output logic INSTR_EVT_VALID_OUT,
    output logic [`BSC_IR_W-1:0] INSTR_EVT_DATA_OUT,
    input wire logic INSTR_EVT_READY_IN,
    output logic INSTR_EVT_SPACE_OUT
);

    localparam int BIDIR_BASE = `BSC_POS_CFG_BASE + NUM_CFG;
    localparam int CHAIN = BIDIR_BASE + 2 * NUM_BIDIR;
    localparam int NSYNC = 4 + NUM_CFG + NUM_BIDIR;

    generate
        if (NUM_CFG < 1 || NUM_BIDIR < 1) begin : g_bad_param
            $error("bsc_tap_top needs at least one cell of each kind");
        end
    endgenerate

    // two-flop synchronisers; the first stage feeds only the second
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic tck_prev;

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            sync_a <= '0;
            sync_b <= '0;
            tck_prev <= 1'b0;
        end else begin
            sync_a <= {IO_PIN_IN, CFG_PIN_IN, TRST_N_IN, TDI_IN, TMS_IN, TCK_IN};
            sync_b <= sync_a;
            tck_prev <= sync_b[0];
        end
    end

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tap_rst;
    logic [NUM_CFG-1:0] cfg_s;
    logic [NUM_BIDIR-1:0] io_s;
    logic rise;
    logic fall;

    assign tck_s = sync_b[0];
    assign tms_s = sync_b[1];
    assign tdi_s = sync_b[2];
    assign tap_rst = ~sync_b[3];
    assign cfg_s = sync_b[4 +: NUM_CFG];
    assign io_s = sync_b[4 + NUM_CFG +: NUM_BIDIR];
    assign rise = tck_s & ~tck_prev;
    assign fall = ~tck_s & tck_prev;

    // controller state
    bsc_tap_state_t state;
    bsc_tap_state_t next_state;

    always_comb begin
        next_state = state;
        if (tap_rst) begin
            next_state = ST_RESET;
        end else if (rise) begin
            case (state)
                ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
                ST_IDLE: next_state = tms_s ? ST_SELECT_DR : ST_IDLE;
                ST_SELECT_DR: next_state = tms_s ? ST_SELECT_IR : ST_CAPTURE_DR;
                ST_CAPTURE_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: next_state = tms_s ? ST_UPDATE_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: next_state = tms_s ? ST_UPDATE_DR : ST_SHIFT_DR;
                ST_UPDATE_DR: next_state = tms_s ? ST_SELECT_DR : ST_IDLE;
                ST_SELECT_IR: next_state = tms_s ? ST_RESET : ST_CAPTURE_IR;
                ST_CAPTURE_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: next_state = tms_s ? ST_UPDATE_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: next_state = tms_s ? ST_UPDATE_IR : ST_SHIFT_IR;
                ST_UPDATE_IR: next_state = tms_s ? ST_SELECT_DR : ST_IDLE;
                default: next_state = ST_RESET;
            endcase
        end
    end

    // instruction register and test data registers
    logic [`BSC_IR_W-1:0] instruction_shift_register;
    logic [`BSC_IR_W-1:0] next_ir_shift;
    logic [`BSC_IR_W-1:0] instr;
    logic [`BSC_IR_W-1:0] next_instr;
    logic byp;
    logic next_byp;
    logic [CHAIN-1:0] bsr_shift;
    logic [CHAIN-1:0] next_bsr_shift;
    logic [CHAIN-1:0] bsr_upd;
    logic [CHAIN-1:0] next_bsr_upd;
    logic [CHAIN-1:0] cap;
    logic tdo;
    logic next_tdo;
    logic tdo_oe_n;
    logic next_tdo_oe_n;
    logic is_ext;
    logic is_smp;
    logic dr_bsr;
    logic evt_push;

    // unknown and reserved codes fall back to the bypass path
    assign is_ext = (instr == `BSC_OP_EXTEST);
    assign is_smp = (instr == `BSC_OP_SAMPLE);
    assign dr_bsr = is_ext | is_smp;

    // capture view: outputs sample what is driven, inputs the pin
    assign cap[`BSC_POS_ENUM_DATA] = ENUM_N_OUT;
    assign cap[`BSC_POS_ENUM_CTRL] = ~ENUM_OE_N_OUT;
    assign cap[`BSC_POS_CFG_BASE +: NUM_CFG] = cfg_s;

    genvar k;
    generate
        for (k = 0; k < NUM_BIDIR; k++) begin : g_bidir_cap
            assign cap[BIDIR_BASE + 2 * k] = io_s[k];
            assign cap[BIDIR_BASE + 2 * k + 1] = ~IO_OE_N_OUT[k];
        end
    endgenerate

    always_comb begin
        next_ir_shift = instruction_shift_register;
        next_byp = byp;
        next_bsr_shift = bsr_shift;
        if (rise && !tap_rst) begin
            case (state)
                ST_CAPTURE_IR: next_ir_shift = `BSC_IR_CAPTURE;
                ST_SHIFT_IR: next_ir_shift = {tdi_s, instruction_shift_register[`BSC_IR_W-1:1]};
                ST_CAPTURE_DR: begin
                    if (dr_bsr) begin
                        next_bsr_shift = cap;
                    end else begin
                        next_byp = 1'b0;
                    end
                end
                ST_SHIFT_DR: begin
                    if (dr_bsr) begin
                        next_bsr_shift = {tdi_s, bsr_shift[CHAIN-1:1]};
                    end else begin
                        next_byp = tdi_s;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_instr = instr;
        next_bsr_upd = bsr_upd;
        next_tdo = tdo;
        next_tdo_oe_n = tdo_oe_n;
        evt_push = 1'b0;
        if (tap_rst || state == ST_RESET) begin
            next_instr = `BSC_OP_IDCODE;
            next_tdo_oe_n = 1'b1;
        end else if (fall) begin
            if (state == ST_UPDATE_IR) begin
                next_instr = instruction_shift_register;
                evt_push = 1'b1;
            end
            if (state == ST_UPDATE_DR && dr_bsr) begin
                next_bsr_upd = bsr_shift;
            end
            if (state == ST_SHIFT_IR) begin
                next_tdo = instruction_shift_register[0];
            end else if (state == ST_SHIFT_DR) begin
                next_tdo = dr_bsr ? bsr_shift[0] : byp;
            end
            next_tdo_oe_n = !(state == ST_SHIFT_IR || state == ST_SHIFT_DR);
        end
    end

    // pin and core-side muxes, registered so every port comes from a flop
    logic next_enum_n;
    logic next_enum_oe_n;
    logic [NUM_CFG-1:0] next_cfg_core;
    logic [NUM_BIDIR-1:0] next_io_pin;
    logic [NUM_BIDIR-1:0] next_io_oe_n;
    logic [NUM_BIDIR-1:0] next_io_core;
    logic [NUM_BIDIR-1:0] upd_data;
    logic [NUM_BIDIR-1:0] upd_ctrl;

    generate
        for (k = 0; k < NUM_BIDIR; k++) begin : g_bidir_upd
            assign upd_data[k] = bsr_upd[BIDIR_BASE + 2 * k];
            assign upd_ctrl[k] = bsr_upd[BIDIR_BASE + 2 * k + 1];
        end
    endgenerate

    // sample and bypass leave the functional paths untouched
    always_comb begin
        next_enum_n = is_ext ? bsr_upd[`BSC_POS_ENUM_DATA] : ENUM_N_CORE_IN;
        next_enum_oe_n = is_ext ? ~bsr_upd[`BSC_POS_ENUM_CTRL] : ~ENUM_OE_CORE_IN;
        next_cfg_core = is_ext ? bsr_upd[`BSC_POS_CFG_BASE +: NUM_CFG] : cfg_s;
        next_io_pin = is_ext ? upd_data : IO_CORE_DATA_IN;
        next_io_oe_n = is_ext ? ~upd_ctrl : ~IO_CORE_OE_IN;
        next_io_core = is_ext ? upd_data : io_s;
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state <= ST_RESET;
            instruction_shift_register <= '0;
            instr <= `BSC_OP_IDCODE;
            byp <= 1'b0;
            bsr_shift <= '0;
            bsr_upd <= '0;
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
            ENUM_N_OUT <= 1'b1;
            ENUM_OE_N_OUT <= 1'b1;
            CFG_CORE_OUT <= '0;
            IO_PIN_OUT <= '0;
            IO_OE_N_OUT <= '1;
            IO_CORE_DATA_OUT <= '0;
        end else begin
            state <= next_state;
            instruction_shift_register <= next_ir_shift;
            instr <= next_instr;
            byp <= next_byp;
            bsr_shift <= next_bsr_shift;
            bsr_upd <= next_bsr_upd;
            tdo <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
            ENUM_N_OUT <= next_enum_n;
            ENUM_OE_N_OUT <= next_enum_oe_n;
            CFG_CORE_OUT <= next_cfg_core;
            IO_PIN_OUT <= next_io_pin;
            IO_OE_N_OUT <= next_io_oe_n;
            IO_CORE_DATA_OUT <= next_io_core;
        end
    end

    assign TDO_OUT = tdo;
    assign TDO_OE_N_OUT = tdo_oe_n;
    assign INSTR_OUT = instr;

    // a full buffer drops the event; INSTR_EVT_SPACE_OUT warns the consumer
    bsc_evt_fifo #(
        .WIDTH(`BSC_IR_W),
        .DEPTH(EVT_DEPTH)
    ) u_evt_fifo (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .in_valid_in(evt_push),
        .in_data_in(instruction_shift_register),
        .in_ready_out(INSTR_EVT_SPACE_OUT),
        .out_valid_out(INSTR_EVT_VALID_OUT),
        .out_data_out(INSTR_EVT_DATA_OUT),
        .out_ready_in(INSTR_EVT_READY_IN)
    );

    // helper for the mode-high reset check
    logic [2:0] ones_cnt;
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ones_cnt <= 3'h0;
        end else if (rise) begin
            ones_cnt <= tms_s ? ((ones_cnt == 3'h7) ? ones_cnt : ones_cnt + 3'h1) : 3'h0;
        end
    end

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    a_trst_forces_reset: assert property (tap_rst |=> state == ST_RESET && instr == `BSC_OP_IDCODE)
        else $error("test reset did not force reset state and id instruction");
    a_tms_five_reset: assert property (ones_cnt >= 3'(`BSC_TLR_TMS_RISES) |-> state == ST_RESET)
        else $error("five mode-high rises did not reach reset");
    a_state_on_rise: assert property (!rise && !tap_rst |=> $stable(state))
        else $error("controller moved without a rising test clock");
    a_ir_capture_val: assert property (rise && !tap_rst && state == ST_CAPTURE_IR |=> instruction_shift_register == 4'hd)
        else $error("instruction capture did not load 1101");
    a_instr_on_fall: assert property (!fall && !tap_rst && state != ST_RESET |=> $stable(instr))
        else $error("instruction changed away from a falling edge");
    a_tdo_on_fall: assert property (!fall && !tap_rst && state != ST_RESET |=> $stable(TDO_OUT) && $stable(TDO_OE_N_OUT))
        else $error("tdo changed away from a falling edge");
    a_tdo_hiz_idle: assert property (fall && state != ST_SHIFT_IR && state != ST_SHIFT_DR |=> TDO_OE_N_OUT)
        else $error("tdo driven outside shift states");
    a_extest_enum_drive: assert property (is_ext ##1 is_ext |-> ENUM_N_OUT == $past(bsr_upd[0]))
        else $error("extest output does not follow the update cell");
    a_ctrl_zero_hiz: assert property (is_ext && !bsr_upd[1] |=> ENUM_OE_N_OUT)
        else $error("zero control cell did not release the pin");
    a_bypass_shift_bit: assert property (rise && !tap_rst && state == ST_SHIFT_DR && instr == `BSC_OP_BYPASS |=> byp == $past(tdi_s))
        else $error("bypass bit did not take tdi");
    a_sample_update_copy: assert property (fall && !tap_rst && state == ST_UPDATE_DR && is_smp |=> bsr_upd == $past(bsr_shift))
        else $error("sample update did not copy the master cells");

endmodule : bsc_tap_top
